// ===== hw/ccp_regs.svh
// timing counts and protocol codes of the card character link
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH
`define CCP_FI_DEF     372
`define CCP_DI_DEF     1
`define CCP_ETU_CLKS   (`CCP_FI_DEF / `CCP_DI_DEF)
`define CCP_HALF_CLKS  (`CCP_ETU_CLKS / 2)
`define CCP_WI_DEF     10
`define CCP_WWT_ETU    (960 * `CCP_WI_DEF)
`define CCP_GAP_SAME   12
`define CCP_GAP_TURN   16
`define CCP_HDR_LEN    5
`define CCP_H_CONFIRM  1
`define CCP_H_LAST     19
`define CCP_H_RELEASE  20
`define CCP_H_ERR_ON   21
`define CCP_H_ERR_CHK  22
`define CCP_H_DONE     24
`define CCP_H_RETRY    28
`define CCP_NULL       8'h60
`define CCP_SW_AVAIL   8'h61
`define CCP_SW_RELEN   8'h6c
`define CCP_SW_HI_A    4'h6
`define CCP_SW_HI_B    4'h9
`define CCP_INS_FETCH  8'hc0
`endif

// ===== hw/ccp_pkg.sv
// shared types and frame coding functions of the card character link
`default_nettype none
package ccp_pkg;
  // character engine states
  typedef enum logic [1:0] {E_IDLE = 2'b00, E_TX = 2'b01, E_RX = 2'b10} ccp_eng_e;
  // terminal command sequencer states
  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_HDR = 3'b001, T_PROC = 3'b010, T_SW2 = 3'b011,
    T_DOUT = 3'b100, T_DIN = 3'b101, T_DEAD = 3'b110
  } ccp_term_e;

  // bit order reversal
  function automatic logic [7:0] ccp_rev(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction : ccp_rev

  // line levels after the start bit, bit 0 first, parity in bit 8
  function automatic logic [8:0] ccp_encode(input logic [7:0] d, input logic inv);
    return inv ? ~{^d, ccp_rev(d)} : {^d, d};
  endfunction : ccp_encode

  // sampled levels to {parity ok, byte}
  function automatic logic [8:0] ccp_decode(input logic [8:0] lv, input logic inv);
    logic [8:0] lg;
    lg = inv ? ~lv : lv;
    return {~^lg, inv ? ccp_rev(lg[7:0]) : lg[7:0]};
  endfunction : ccp_decode
endpackage : ccp_pkg
`default_nettype wire

// ===== hw/ccp_link_if.sv
// shared single io line between card end and terminal end
`default_nettype none
interface ccp_link_if;
  logic card_io_o;
  logic card_io_oe_n;
  logic term_io_o;
  logic term_io_oe_n;
  logic io_line;
  // open drain with pull-up: high unless an enabled end drives low
  assign io_line = (card_io_oe_n | card_io_o) & (term_io_oe_n | term_io_o);
  modport card (output card_io_o, output card_io_oe_n, input io_line);
  modport term (output term_io_o, output term_io_oe_n, input io_line);
endinterface : ccp_link_if
`default_nettype wire

// ===== hw/ccp_fifo.sv
// byte buffer with valid and ready on both sides
`default_nettype none
module ccp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // filling side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // draining side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    wr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // honest full and empty straight from the count
  assign in_ready_o  = cnt_reg != FULL;
  assign out_valid_o = cnt_reg != '0;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_reg[rd_reg];

  // storage, no reset needed on data words
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : ccp_fifo
`default_nettype wire

// ===== hw/ccp_card.sv
// card end of the character link: character engine and reply keeper
`include "ccp_regs.svh"
`default_nettype none
module ccp_card
  import ccp_pkg::*;
#(
  parameter int unsigned NULL_ETU = `CCP_WWT_ETU / 2
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // link
  ccp_link_if.card        link,
  // reply bytes from the card application
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic       conv_inv_i,
  input  wire logic       hdr_rearm_i,
  // received bytes to the card application
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_hdr_o
);
  ccp_eng_e    eng_reg;
  logic        io_s1_reg, io_s2_reg, io_prev_reg;
  logic [8:0]  clk_cnt_reg;
  logic [4:0]  h_reg;
  logic [9:0]  frame_reg;
  logic [8:0]  rx_reg;
  logic        rx_err_reg, tx_err_reg, low_reg, tx_ok_reg, null_reg;
  logic [8:0]  etu_cnt_reg;
  logic [15:0] gap_reg;
  logic        last_rx_reg, owe_reg;
  logic [2:0]  hcnt_reg;
  logic [7:0]  q_data;
  logic        q_valid;
  logic        half_tick, gap_ok, null_due, tx_req, tx_start, rx_start;
  logic [4:0]  h_next;
  logic [8:0]  dec;

  // entering half-etu index x of the frame
  function automatic logic at_h(input logic [4:0] x);
    return half_tick && (h_next == x);
  endfunction : at_h

  ccp_fifo #(.WIDTH(8), .DEPTH(8)) u_txq (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .in_data_i  (tx_data_i),
    .in_valid_i (tx_valid_i),
    .in_ready_o (tx_ready_o),
    .out_data_o (q_data),
    .out_valid_o(q_valid),
    .out_ready_i(tx_ok_reg && !null_reg)
  );

  // start decisions; line belongs to card only after a full header
  assign half_tick = clk_cnt_reg == 9'(`CCP_HALF_CLKS - 1);
  assign h_next    = h_reg + 5'd1;
  assign gap_ok    = gap_reg >= (last_rx_reg ? 16'(`CCP_GAP_TURN) : 16'(`CCP_GAP_SAME));
  assign null_due  = owe_reg && !q_valid && gap_reg >= 16'(NULL_ETU);
  assign tx_req    = hcnt_reg == 3'(`CCP_HDR_LEN) && (q_valid || null_due);
  assign tx_start  = eng_reg == E_IDLE && tx_req && gap_ok && io_s2_reg && !tx_ok_reg;
  assign rx_start  = eng_reg == E_IDLE && !tx_start && io_prev_reg && !io_s2_reg;
  assign dec       = ccp_decode(rx_reg, conv_inv_i);

  // line synchroniser
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_s1_reg   <= 1'b1;
      io_s2_reg   <= 1'b1;
      io_prev_reg <= 1'b1;
    end else begin
      io_s1_reg   <= link.io_line;
      io_s2_reg   <= io_s1_reg;
      io_prev_reg <= io_s2_reg;
    end
  end

  // etu time base since the last start edge
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      etu_cnt_reg <= '0;
      gap_reg     <= 16'(`CCP_GAP_TURN);
      last_rx_reg <= 1'b0;
    end else if (tx_start || rx_start) begin
      etu_cnt_reg <= '0;
      gap_reg     <= '0;
      last_rx_reg <= rx_start;
    end else if (etu_cnt_reg == 9'(`CCP_ETU_CLKS - 1)) begin
      etu_cnt_reg <= '0;
      gap_reg     <= (gap_reg == '1) ? gap_reg : gap_reg + 16'd1;
    end else begin
      etu_cnt_reg <= etu_cnt_reg + 9'd1;
    end
  end

  // character engine
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eng_reg     <= E_IDLE;
      clk_cnt_reg <= '0;
      h_reg       <= '0;
      frame_reg   <= '1;
      rx_reg      <= '0;
      rx_err_reg  <= 1'b0;
      tx_err_reg  <= 1'b0;
      tx_ok_reg   <= 1'b0;
      null_reg    <= 1'b0;
      rx_valid_o  <= 1'b0;
      rx_data_o   <= '0;
    end else begin
      tx_ok_reg   <= 1'b0;
      rx_valid_o  <= 1'b0;
      clk_cnt_reg <= (eng_reg == E_IDLE || half_tick) ? '0 : clk_cnt_reg + 9'd1;
      if (half_tick) begin
        h_reg <= h_next;
      end
      case (eng_reg)
        E_IDLE: begin
          h_reg      <= '0;
          rx_err_reg <= 1'b0;
          tx_err_reg <= 1'b0;
          if (tx_start) begin
            eng_reg   <= E_TX;
            null_reg  <= !q_valid;
            frame_reg <= {ccp_encode(q_valid ? q_data : `CCP_NULL, conv_inv_i), 1'b0};
          end else if (rx_start) begin
            eng_reg <= E_RX;
          end
        end
        E_TX: begin
          if (at_h(5'(`CCP_H_ERR_CHK))) begin
            tx_err_reg <= !io_s2_reg;
          end
          if (at_h(5'(`CCP_H_DONE)) && !tx_err_reg) begin
            eng_reg   <= E_IDLE;
            tx_ok_reg <= 1'b1;
          end
          if (at_h(5'(`CCP_H_RETRY))) begin
            eng_reg <= E_IDLE; // byte stays queued, resent later
          end
        end
        E_RX: begin
          if (at_h(5'(`CCP_H_CONFIRM)) && io_s2_reg) begin
            eng_reg <= E_IDLE;
          end
          if (half_tick && h_next[0] && h_next > 5'd2 && h_next <= 5'(`CCP_H_LAST)) begin
            rx_reg <= {io_s2_reg, rx_reg[8:1]};
          end
          if (at_h(5'(`CCP_H_ERR_ON))) begin
            if (dec[8]) begin
              eng_reg    <= E_IDLE;
              rx_valid_o <= 1'b1;
              rx_data_o  <= dec[7:0];
            end else begin
              rx_err_reg <= 1'b1;
            end
          end
          if (at_h(5'(`CCP_H_DONE))) begin
            eng_reg <= E_IDLE;
          end
        end
        default: eng_reg <= E_IDLE;
      endcase
    end
  end

  // line drive: frame bits while sending, error pulse while receiving
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_reg <= 1'b0;
    end else begin
      low_reg <= (eng_reg == E_TX && h_reg < 5'(`CCP_H_RELEASE) && !frame_reg[h_reg[4:1]]) ||
                 (eng_reg == E_RX && rx_err_reg && h_reg >= 5'(`CCP_H_ERR_ON) &&
                  h_reg < 5'(`CCP_H_DONE));
    end
  end
  assign link.card_io_o    = 1'b0;
  assign link.card_io_oe_n = !low_reg;

  // header count and reply debt
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hcnt_reg <= '0;
      owe_reg  <= 1'b0;
      rx_hdr_o <= 1'b0;
    end else begin
      if (rx_valid_o && hcnt_reg != 3'(`CCP_HDR_LEN)) begin
        hcnt_reg <= hcnt_reg + 3'd1;
      end
      if (eng_reg == E_RX && at_h(5'(`CCP_H_ERR_ON)) && dec[8]) begin
        rx_hdr_o <= hcnt_reg != 3'(`CCP_HDR_LEN);
      end
      if (tx_ok_reg && !null_reg) begin
        owe_reg <= 1'b0;
      end
      if (rx_valid_o && (hcnt_reg >= 3'(`CCP_HDR_LEN - 1))) begin
        owe_reg <= 1'b1; // set wins over clear
      end
      if (hdr_rearm_i) begin
        hcnt_reg <= '0;
      end
    end
  end
endmodule : ccp_card
`default_nettype wire

// ===== hw/ccp_term.sv
// terminal end of the card character link: character engine and command sequencer
`include "ccp_regs.svh"
`default_nettype none
// Behaviour
// - line rests high before each character
// - direct one is high, inverse one low
// - start bit, eight data, one parity
// - even parity over data and parity
// - confirm start, sample at n plus half
// - guard time both released in receive
// - bit order set by convention choice
// - terminal opens command with five-byte header
// - start edges at least twelve etu apart
// - card keeps within work waiting time
// - terminal deactivates after waiting time expiry
// - sixteen etu when direction turns round
// - card answers header with procedure byte
// - INS echo moves all remaining data; here every echo reloads remain_reg with full_len
// - complement of INS moves one byte
// - NULL byte only extends the wait
// - 61 fetches response of length SW2
// - 6C resends header with SW2 length
// - procedure bytes never reach the application
// - other 6X or 9X ends command
// - receiver pulls line low on parity error
// - sender checks at eleven etu, resends
module ccp_term
  import ccp_pkg::*;
#(
  parameter int unsigned WWT_ETU = `CCP_WWT_ETU
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // link
  ccp_link_if.term         link,
  // command bytes from the application
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire logic        cmd_out_i,
  input  wire logic        conv_inv_i,
  // response to the application
  output logic [7:0]       rx_data_o,
  output logic             rx_valid_o,
  output logic [15:0]      sw_o,
  output logic             sw_valid_o,
  output logic             busy_o,
  output logic             deact_o
);
  ccp_eng_e    eng_reg;
  ccp_term_e   st_reg;
  logic        io_s1_reg, io_s2_reg, io_prev_reg;
  logic [8:0]  clk_cnt_reg;
  logic [4:0]  h_reg;
  logic [9:0]  frame_reg;
  logic [8:0]  rx_reg;
  logic [7:0]  sent_reg, rx_byte_reg, sw1_reg;
  logic        rx_err_reg, tx_err_reg, low_reg, tx_ok_reg, rx_ok_reg;
  logic [8:0]  etu_cnt_reg, remain_reg, full_len;
  logic [15:0] gap_reg;
  logic        last_rx_reg, gen_reg, dir_out_reg;
  logic [7:0]  hdr_reg [`CCP_HDR_LEN];
  logic [2:0]  hcnt_reg;
  logic [7:0]  q_data, tx_byte;
  logic        q_valid, q_pop;
  logic        half_tick, gap_ok, tx_req, tx_start, rx_start;
  logic [4:0]  h_next;
  logic [8:0]  dec;

  // entering half-etu index x of the frame
  function automatic logic at_h(input logic [4:0] x);
    return half_tick && (h_next == x);
  endfunction : at_h

  // queue stalls the application while the card holds off data
  ccp_fifo #(.WIDTH(8), .DEPTH(8)) u_txq (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .in_data_i  (tx_data_i),
    .in_valid_i (tx_valid_i),
    .in_ready_o (tx_ready_o),
    .out_data_o (q_data),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop)
  );

  // byte source and start decisions
  assign half_tick = clk_cnt_reg == 9'(`CCP_HALF_CLKS - 1);
  assign h_next    = h_reg + 5'd1;
  assign gap_ok    = gap_reg >= (last_rx_reg ? 16'(`CCP_GAP_TURN) : 16'(`CCP_GAP_SAME));
  assign tx_byte   = (st_reg == T_HDR && gen_reg) ? hdr_reg[hcnt_reg] : q_data;
  assign tx_req    = (st_reg == T_HDR && (gen_reg || q_valid)) || (st_reg == T_DOUT && q_valid);
  assign tx_start  = eng_reg == E_IDLE && tx_req && gap_ok && io_s2_reg && !tx_ok_reg;
  assign rx_start  = eng_reg == E_IDLE && !tx_start && io_prev_reg && !io_s2_reg;
  assign q_pop     = tx_ok_reg && !gen_reg && (st_reg == T_HDR || st_reg == T_DOUT);
  assign dec       = ccp_decode(rx_reg, conv_inv_i);
  assign full_len  = (hdr_reg[4] == 8'h00 && !dir_out_reg) ? 9'd256 : {1'b0, hdr_reg[4]};
  assign busy_o    = st_reg != T_IDLE;

  // line synchroniser
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_s1_reg   <= 1'b1;
      io_s2_reg   <= 1'b1;
      io_prev_reg <= 1'b1;
    end else begin
      io_s1_reg   <= link.io_line;
      io_s2_reg   <= io_s1_reg;
      io_prev_reg <= io_s2_reg;
    end
  end

  // etu time base since the last start edge of either side
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      etu_cnt_reg <= '0;
      gap_reg     <= 16'(`CCP_GAP_TURN);
      last_rx_reg <= 1'b0;
    end else if (tx_start || rx_start) begin
      etu_cnt_reg <= '0;
      gap_reg     <= '0;
      last_rx_reg <= rx_start;
    end else if (etu_cnt_reg == 9'(`CCP_ETU_CLKS - 1)) begin
      etu_cnt_reg <= '0;
      gap_reg     <= (gap_reg == '1) ? gap_reg : gap_reg + 16'd1;
    end else begin
      etu_cnt_reg <= etu_cnt_reg + 9'd1;
    end
  end

  // character engine
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eng_reg     <= E_IDLE;
      clk_cnt_reg <= '0;
      h_reg       <= '0;
      frame_reg   <= '1;
      sent_reg    <= '0;
      rx_reg      <= '0;
      rx_byte_reg <= '0;
      rx_err_reg  <= 1'b0;
      tx_err_reg  <= 1'b0;
      tx_ok_reg   <= 1'b0;
      rx_ok_reg   <= 1'b0;
    end else begin
      tx_ok_reg   <= 1'b0;
      rx_ok_reg   <= 1'b0;
      clk_cnt_reg <= (eng_reg == E_IDLE || half_tick) ? '0 : clk_cnt_reg + 9'd1;
      if (half_tick) begin
        h_reg <= h_next;
      end
      case (eng_reg)
        E_IDLE: begin
          h_reg      <= '0;
          rx_err_reg <= 1'b0;
          tx_err_reg <= 1'b0;
          if (tx_start) begin
            eng_reg   <= E_TX;
            sent_reg  <= tx_byte;
            frame_reg <= {ccp_encode(tx_byte, conv_inv_i), 1'b0};
          end else if (rx_start) begin
            eng_reg <= E_RX;
          end
        end
        E_TX: begin
          if (at_h(5'(`CCP_H_ERR_CHK))) begin
            tx_err_reg <= !io_s2_reg;
          end
          if (at_h(5'(`CCP_H_DONE)) && !tx_err_reg) begin
            eng_reg   <= E_IDLE;
            tx_ok_reg <= 1'b1;
          end
          if (at_h(5'(`CCP_H_RETRY))) begin
            eng_reg <= E_IDLE; // byte not consumed, goes again
          end
        end
        E_RX: begin
          if (at_h(5'(`CCP_H_CONFIRM)) && io_s2_reg) begin
            eng_reg <= E_IDLE; // glitch, no start bit
          end
          if (half_tick && h_next[0] && h_next > 5'd2 && h_next <= 5'(`CCP_H_LAST)) begin
            rx_reg <= {io_s2_reg, rx_reg[8:1]};
          end
          if (at_h(5'(`CCP_H_ERR_ON))) begin
            if (dec[8]) begin
              eng_reg     <= E_IDLE;
              rx_ok_reg   <= 1'b1;
              rx_byte_reg <= dec[7:0];
            end else begin
              rx_err_reg <= 1'b1;
            end
          end
          if (at_h(5'(`CCP_H_DONE))) begin
            eng_reg <= E_IDLE;
          end
        end
        default: eng_reg <= E_IDLE;
      endcase
    end
  end

  // line drive: frame bits while sending, 1.5 etu error pulse while receiving
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_reg <= 1'b0;
    end else begin
      low_reg <= (eng_reg == E_TX && h_reg < 5'(`CCP_H_RELEASE) && !frame_reg[h_reg[4:1]]) ||
                 (eng_reg == E_RX && rx_err_reg && h_reg >= 5'(`CCP_H_ERR_ON) &&
                  h_reg < 5'(`CCP_H_DONE));
    end
  end
  assign link.term_io_o    = 1'b0;
  assign link.term_io_oe_n = !low_reg;

  // command sequencer
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg      <= T_IDLE;
      hcnt_reg    <= '0;
      gen_reg     <= 1'b0;
      dir_out_reg <= 1'b0;
      remain_reg  <= '0;
      sw1_reg     <= '0;
      hdr_reg     <= '{default: 8'h00};
      rx_data_o   <= '0;
      rx_valid_o  <= 1'b0;
      sw_o        <= '0;
      sw_valid_o  <= 1'b0;
      deact_o     <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      sw_valid_o <= 1'b0;
      case (st_reg)
        T_IDLE: if (q_valid) begin
          st_reg      <= T_HDR;
          hcnt_reg    <= '0;
          gen_reg     <= 1'b0;
          dir_out_reg <= cmd_out_i;
        end
        T_HDR: if (tx_ok_reg) begin
          hdr_reg[hcnt_reg] <= sent_reg; // kept for a later resend
          hcnt_reg          <= hcnt_reg + 3'd1;
          if (hcnt_reg == 3'(`CCP_HDR_LEN - 1)) begin
            st_reg  <= T_PROC;
            gen_reg <= 1'b0;
          end
        end
        T_PROC: if (rx_ok_reg) begin
          if (rx_byte_reg == hdr_reg[1]) begin
            remain_reg <= full_len;
            if (full_len != '0) begin
              st_reg <= dir_out_reg ? T_DOUT : T_DIN;
            end
          end else if (rx_byte_reg == ~hdr_reg[1]) begin
            remain_reg <= 9'd1;
            st_reg     <= dir_out_reg ? T_DOUT : T_DIN;
          end else if ((rx_byte_reg[7:4] == `CCP_SW_HI_A || rx_byte_reg[7:4] == `CCP_SW_HI_B) &&
                       rx_byte_reg != `CCP_NULL) begin
            sw1_reg <= rx_byte_reg;
            st_reg  <= T_SW2;
          end
        end
        T_SW2: if (rx_ok_reg) begin
          if (sw1_reg == `CCP_SW_AVAIL) begin
            hdr_reg[1]  <= `CCP_INS_FETCH;
            hdr_reg[2]  <= 8'h00;
            hdr_reg[3]  <= 8'h00;
            hdr_reg[4]  <= rx_byte_reg;
            dir_out_reg <= 1'b0;
            gen_reg     <= 1'b1;
            hcnt_reg    <= '0;
            st_reg      <= T_HDR;
          end else if (sw1_reg == `CCP_SW_RELEN) begin
            hdr_reg[4] <= rx_byte_reg;
            gen_reg    <= 1'b1;
            hcnt_reg   <= '0;
            st_reg     <= T_HDR;
          end else begin
            sw_o       <= {sw1_reg, rx_byte_reg};
            sw_valid_o <= 1'b1;
            st_reg     <= T_IDLE;
          end
        end
        T_DOUT: if (tx_ok_reg) begin
          remain_reg <= remain_reg - 9'd1;
          if (remain_reg == 9'd1) begin
            st_reg <= T_PROC;
          end
        end
        T_DIN: if (rx_ok_reg) begin
          rx_data_o  <= rx_byte_reg; // only data goes up
          rx_valid_o <= 1'b1;
          remain_reg <= remain_reg - 9'd1;
          if (remain_reg == 9'd1) begin
            st_reg <= T_PROC;
          end
        end
        T_DEAD: deact_o <= 1'b1;
        default: st_reg <= T_IDLE;
      endcase
      // card silent past the waiting time: give up at once
      if ((st_reg == T_PROC || st_reg == T_SW2 || st_reg == T_DIN) && eng_reg == E_IDLE &&
          gap_reg >= 16'(WWT_ETU)) begin
        st_reg  <= T_DEAD;
        deact_o <= 1'b1;
      end
    end
  end
endmodule : ccp_term
`default_nettype wire

// ===== sim/ccp_link_properties.sv
// assertions on the shared card link line
`default_nettype none
module ccp_link_properties (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // link
  input wire logic card_io_o,
  input wire logic card_io_oe_n,
  input wire logic term_io_o,
  input wire logic term_io_oe_n,
  input wire logic io_line,
  // character convention
  input wire logic conv_inv_i
);
  localparam int E = 372;
  int         n_reg;
  logic       q_reg;
  logic       own_reg;
  logic [8:0] lv_reg;
  logic       fall_w;
  logic       st_w;
  assign fall_w = !io_line && q_reg;
  // falls before 11 etu are data bits or an error pulse
  assign st_w = fall_w && n_reg >= 11 * E;
  // clocks since start edge, saturating; level parity flips under inverse convention
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      n_reg <= 99 * E;
      q_reg <= 1'b1;
      own_reg <= 1'b0;
      lv_reg <= 9'h000;
    end else begin
      q_reg <= io_line;
      n_reg <= st_w ? 1 : n_reg + int'(n_reg < 99 * E);
      if (st_w) own_reg <= !card_io_oe_n;
      if (n_reg % E == E / 2 && n_reg > E && n_reg < 10 * E) lv_reg <= {io_line, lv_reg[8:1]};
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_open_drain: assert property (!card_io_o && !term_io_o) else $error("io data high");
  a_idle_high: assert property (n_reg >= 13 * E && !fall_w |-> io_line) else $error("line low idle");
  a_start_bit_low: assert property (n_reg >= 1 && n_reg < E - 4 |-> !io_line) else $error("short start");
  a_parity_even: assert property (n_reg == 10 * E |-> ^lv_reg == conv_inv_i) else $error("odd parity");
  a_guard_released: assert property (n_reg > 10 * E + 4 && n_reg < 10 * E + 180 |-> card_io_oe_n && term_io_oe_n)
    else $error("line held");
  a_gap_twelve: assert property (fall_w && n_reg >= 11 * E |-> n_reg >= 12 * E) else $error("gap short");
  a_turn_sixteen: assert property (st_w && !card_io_oe_n != own_reg |-> n_reg >= 16 * E) else $error("turn short");
  a_one_owner: assert property (card_io_oe_n || term_io_oe_n) else $error("both drive");
  c_term_start: cover property (st_w && !term_io_oe_n);
  c_card_start: cover property (st_w && !card_io_oe_n);
  c_turn: cover property (st_w && !card_io_oe_n != own_reg);
endmodule : ccp_link_properties
`default_nettype wire

// ===== sim/card_char_protocol_link_bench.sv
// bench joining terminal and card ends across one link
`default_nettype none
module card_char_protocol_link_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        t_valid = 1'b0;
  logic        c_valid = 1'b0;
  logic        conv = 1'b0;
  logic        rearm = 1'b0;
  logic [7:0]  t_data = 8'h00;
  logic [7:0]  c_data = 8'h00;
  logic [7:0]  t_rx, c_rx;
  logic [15:0] sw;
  logic        t_ready, c_ready, t_rxv, c_rxv, c_hdr, swv, busy, deact;
  int          num_errors = 0;
  int          check_count = 0;
  int          ci = 0;
  int          ti = 0;
  // header rows; card replies, whose data part the terminal must deliver
  logic [7:0]  hdr [5] = '{8'h00, 8'hb0, 8'h00, 8'h00, 8'h04};
  logic [7:0]  crow [8] = '{8'h60, 8'hb0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h90, 8'h00};
  always #20 clk_sys_i = ~clk_sys_i;
  ccp_link_if u_ccp_link_if ();
  ccp_term #(.WWT_ETU(200)) u_ccp_term (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(u_ccp_link_if),
    .tx_data_i(t_data), .tx_valid_i(t_valid), .tx_ready_o(t_ready), .cmd_out_i(1'b0), .conv_inv_i(conv),
    .rx_data_o(t_rx), .rx_valid_o(t_rxv), .sw_o(sw), .sw_valid_o(swv), .busy_o(busy), .deact_o(deact));
  ccp_card #(.NULL_ETU(60)) u_ccp_card (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(u_ccp_link_if),
    .tx_data_i(c_data), .tx_valid_i(c_valid), .tx_ready_o(c_ready), .conv_inv_i(conv), .hdr_rearm_i(rearm),
    .rx_data_o(c_rx), .rx_valid_o(c_rxv), .rx_hdr_o(c_hdr));
  ccp_link_properties u_ccp_link_properties (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .card_io_o(u_ccp_link_if.card_io_o), .card_io_oe_n(u_ccp_link_if.card_io_oe_n),
    .term_io_o(u_ccp_link_if.term_io_o), .term_io_oe_n(u_ccp_link_if.term_io_oe_n), .io_line(u_ccp_link_if.io_line),
    .conv_inv_i(conv));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // one loop over the rows; valid held until ready seen at an edge
  task automatic push(input logic card, input int s, input int n);
    for (int i = s; i < n; i++) begin
      if (card) c_data = crow[i];
      else t_data = hdr[i];
      c_valid = card;
      t_valid = !card;
      while ((card ? c_ready : t_ready) !== 1'b1) @(posedge clk_sys_i) #1;
      @(posedge clk_sys_i) #1;
    end
    c_valid = 1'b0;
    t_valid = 1'b0;
  endtask : push
  // pulses are read at the edge after they rise, so no race
  always @(posedge clk_sys_i) begin
    if (c_rxv === 1'b1) begin
      check(16'(c_rx), 16'(hdr[ci % 5]));
      check(16'(c_hdr), 16'h0001);
      ci++;
    end
    if (t_rxv === 1'b1) begin
      check(16'(t_rx), 16'(crow[2 + ti % 4]));
      ti++;
    end
    if (swv === 1'b1) check(sw, 16'h9000);
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    check(16'(u_ccp_link_if.io_line), 16'h0001);
    // second pass: inverse convention, card rearmed, status straight after header
    for (int r = 0; r < 2; r++) begin
      push(1'b1, 6 * r, 8);
      check(16'(c_ready), 16'(r));
      push(1'b0, 0, 5);
      wait (swv === 1'b1);
      repeat (400) @(posedge clk_sys_i);
      #1 conv = 1'b1;
      rearm = 1'b1;
      @(posedge clk_sys_i) #1 rearm = 1'b0;
    end
    check(16'(ci), 16'h000a);
    check(16'(ti), 16'h0004);
    check(16'({busy, deact, c_ready}), 16'h0001);
    complete_run();
  end
  // both exchanges take about 253 etu; 268 etu means a hang
  initial begin
    #(268 * 372 * 40);
    num_errors++;
    complete_run();
  end
endmodule : card_char_protocol_link_bench
`default_nettype wire
